// File: core/sclk_defs.vh
// Purpose: constants for the synthesizer clock-output and lock control block
// Assumes: register offsets are this design's own word indices on a plain port
// Notes: offsets, field positions and reset values live here, except the status bits and write masks
//
// What this block does
// (R01) With the output enable set, drive a power-of-two sub-multiple of the reference, /2 to /256, on the pin.
// (R02) The divider field selects the division ratio applied before the clock output pin.
// (R03) The reference clock output is available in every mode except sleep.
// (R04) The clock output enable resets to on, so the output runs unconfigured.
// (R05) Controller programs the VCO band code from the target channel range.
// (R06) VCO trim starts at zero; each step raises tuning voltage about 60 mV.
// (R07) The lock detector result is readable as a flag in interrupt register space.
// (R08) The lock flag clears only when a one is written to it.
// (R09) With the lock pin enable set, the lock status shows on the lock pin.
// (R10) Controller sets reference divider near 119, about 100 kHz comparison.
// (R11) Controller keeps R within 64 to 169 and S below P plus one.
// (R12) The lock flag sets on detector lock and holds until cleared.
`ifndef SCLK_DEFS_VH
`define SCLK_DEFS_VH

`define SCLK_ADDR_W 4
`define SCLK_DATA_W 8

`define SCLK_REG_REFOUT 4'h0
`define SCLK_REG_VCO 4'h1
`define SCLK_REG_IRQ_STAT 4'h2
`define SCLK_REG_IRQ_MASK 4'h3
`define SCLK_REG_IRQ_CTRL 4'h4
`define SCLK_REG_STATUS 4'h5

// refout register
`define SCLK_REFOUT_EN_BIT 7
`define SCLK_REFOUT_DIV_LSB 0
`define SCLK_REFOUT_DIV_W 3
`define SCLK_REFOUT_RESET 8'h80

// vco register: band in [2:0], trim in [5:4]
`define SCLK_VCO_BAND_LSB 0
`define SCLK_VCO_BAND_W 3
`define SCLK_VCO_TRIM_LSB 4
`define SCLK_VCO_TRIM_W 2
`define SCLK_VCO_RESET 8'h00

// interrupt status/mask layout
`define SCLK_IRQ_LOCK_BIT 0
`define SCLK_IRQ_UNLOCK_BIT 1
`define SCLK_IRQ_RESET 8'h00

// irq control register
`define SCLK_CTRL_LOCKPIN_BIT 0
`define SCLK_CTRL_RESET 8'h00

`endif

// File: core/sclk_synth_ctrl.v
// Purpose: control/status for the clock output, VCO settings and PLL lock flag
// Assumes: lock_detect and sleep_mode are asynchronous to clk
// Notes: the output clock is a divided register, not a gated clock
// Notes: lock and sleep reach the logic two clk edges after they change
// Notes: the sticky lock flag sets on a lock edge, so clearing it while
// still locked leaves it clear until the loop drops and locks again
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "sclk_defs.vh"

module sclk_synth_ctrl #(
    parameter ADDR_W = `SCLK_ADDR_W,
    parameter DATA_W = `SCLK_DATA_W
) (
    input wire clk,
    input wire rst_n,
    input wire [ADDR_W-1:0] reg_addr,
    input wire [DATA_W-1:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [DATA_W-1:0] reg_rdata,
    input wire sleep_mode,
    input wire lock_detect,
    output reg refout_clk,
    output reg lock_pin,
    output wire [`SCLK_VCO_BAND_W-1:0] vco_band_select,
    output wire [`SCLK_VCO_TRIM_W-1:0] vco_tank_trim,
    output wire irq
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // one address compare, shared by every write decode
    function addr_hit;
        input [ADDR_W-1:0] addr;
        input [ADDR_W-1:0] index;
        begin
            addr_hit = (addr == index);
        end
    endfunction

    // half period of the output clock in clk cycles: 2^field
    function [7:0] half_period;
        input [`SCLK_REFOUT_DIV_W-1:0] sel;
        begin
            half_period = 8'h01 << sel;
        end
    endfunction

    // one sticky bit: a hardware set beats a software clear in the same cycle
    function sticky_next;
        input old;
        input clr;
        input set;
        begin
            sticky_next = set | (old & ~clr);
        end
    endfunction

    // ----------------------------------------------------------------
    // write masks
    // ----------------------------------------------------------------
    // unused bits are dropped on write so they always read back as zero
    localparam [DATA_W-1:0] REFOUT_WMASK = 8'h87;
    localparam [DATA_W-1:0] VCO_WMASK = 8'h37;
    localparam [DATA_W-1:0] IRQ_WMASK = 8'h03;
    localparam [DATA_W-1:0] CTRL_WMASK = 8'h01;

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    // both pins are asynchronous to clk; only the second stage is read
    // by any logic, the first may be metastable
    reg sleep_s1;
    reg sleep_s2;
    reg lock_s1;
    reg lock_s2;
    reg lock_prev;
    wire lock_rise;
    wire lock_fall;

    always @(posedge clk) begin
        if (!rst_n) begin
            sleep_s1 <= 1'b0;
            sleep_s2 <= 1'b0;
        end else begin
            sleep_s1 <= sleep_mode;
            sleep_s2 <= sleep_s1;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
        end else begin
            lock_s1 <= lock_detect;
            lock_s2 <= lock_s1;
        end
    end

    // the edge detector resets low, the idle level of an unlocked loop,
    // so no false lock edge follows reset
    always @(posedge clk) begin
        if (!rst_n) begin
            lock_prev <= 1'b0;
        end else begin
            lock_prev <= lock_s2;
        end
    end

    assign lock_rise = lock_s2 & ~lock_prev;
    assign lock_fall = ~lock_s2 & lock_prev;

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    reg [DATA_W-1:0] refout_cfg;
    reg [DATA_W-1:0] vco_cfg;
    reg [DATA_W-1:0] irq_stat;
    reg [DATA_W-1:0] irq_mask;
    reg [DATA_W-1:0] irq_ctrl;
    reg [DATA_W-1:0] next_irq_stat;
    wire wr_refout;
    wire wr_vco;
    wire wr_stat;
    wire wr_mask;
    wire wr_ctrl;
    wire refout_enable_bit;
    wire [`SCLK_REFOUT_DIV_W-1:0] refout_divider_field;
    wire lock_pin_enable_bit;
    wire synth_locked_flag;

    assign wr_refout = reg_write && addr_hit(reg_addr, `SCLK_REG_REFOUT);
    assign wr_vco = reg_write && addr_hit(reg_addr, `SCLK_REG_VCO);
    assign wr_stat = reg_write && addr_hit(reg_addr, `SCLK_REG_IRQ_STAT);
    assign wr_mask = reg_write && addr_hit(reg_addr, `SCLK_REG_IRQ_MASK);
    assign wr_ctrl = reg_write && addr_hit(reg_addr, `SCLK_REG_IRQ_CTRL);

    assign refout_enable_bit = refout_cfg[`SCLK_REFOUT_EN_BIT];
    assign refout_divider_field = refout_cfg[`SCLK_REFOUT_DIV_LSB +: `SCLK_REFOUT_DIV_W];
    assign lock_pin_enable_bit = irq_ctrl[`SCLK_CTRL_LOCKPIN_BIT];
    assign synth_locked_flag = irq_stat[`SCLK_IRQ_LOCK_BIT];

    // the output runs from reset with no write needed
    always @(posedge clk) begin
        if (!rst_n) begin
            refout_cfg <= `SCLK_REFOUT_RESET; // see R04
        end else if (wr_refout) begin
            refout_cfg <= reg_wdata & REFOUT_WMASK;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            vco_cfg <= `SCLK_VCO_RESET; // see R06
        end else if (wr_vco) begin
            vco_cfg <= reg_wdata & VCO_WMASK;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            irq_mask <= `SCLK_IRQ_RESET;
        end else if (wr_mask) begin
            irq_mask <= reg_wdata & IRQ_WMASK;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            irq_ctrl <= `SCLK_CTRL_RESET;
        end else if (wr_ctrl) begin
            irq_ctrl <= reg_wdata & CTRL_WMASK;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status
    // ----------------------------------------------------------------
    // set wins over the write-one clear so a lock edge is never lost
    always @* begin
        next_irq_stat = {DATA_W{1'b0}};
        next_irq_stat[`SCLK_IRQ_LOCK_BIT] = sticky_next(synth_locked_flag,
            wr_stat & reg_wdata[`SCLK_IRQ_LOCK_BIT], lock_rise); // see R08, R12
        next_irq_stat[`SCLK_IRQ_UNLOCK_BIT] = sticky_next(irq_stat[`SCLK_IRQ_UNLOCK_BIT],
            wr_stat & reg_wdata[`SCLK_IRQ_UNLOCK_BIT], lock_fall);
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            irq_stat <= `SCLK_IRQ_RESET;
        end else begin
            irq_stat <= next_irq_stat;
        end
    end

    // level output from two registers only, so it cannot glitch on bus traffic
    assign irq = |(irq_stat & irq_mask);

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    reg [DATA_W-1:0] next_rdata;

    // data stand for exactly the cycle after the strobe, zero otherwise
    always @* begin
        next_rdata = {DATA_W{1'b0}};
        if (reg_read) begin
            case (reg_addr)
                `SCLK_REG_REFOUT: begin
                    next_rdata = refout_cfg;
                end
                `SCLK_REG_VCO: begin
                    next_rdata = vco_cfg;
                end
                `SCLK_REG_IRQ_STAT: begin
                    next_rdata = irq_stat; // see R07
                end
                `SCLK_REG_IRQ_MASK: begin
                    next_rdata = irq_mask;
                end
                `SCLK_REG_IRQ_CTRL: begin
                    next_rdata = irq_ctrl;
                end
                `SCLK_REG_STATUS: begin
                    next_rdata = {6'h00, sleep_s2, lock_s2};
                end
                default: begin
                    next_rdata = {DATA_W{1'b0}};
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= {DATA_W{1'b0}};
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // reference clock output divider
    // ----------------------------------------------------------------
    // clk stands in for the crystal reference; ratio is 2^(field+1)
    // toggling rather than gating keeps the output glitch-free
    reg [7:0] div_cnt;
    reg [7:0] next_div_cnt;
    reg next_refout_clk;
    wire refout_run;
    wire div_wrap;

    assign refout_run = refout_enable_bit && !sleep_s2; // see R03
    assign div_wrap = (div_cnt >= half_period(refout_divider_field) - 8'h01);

    // a disabled or sleeping output parks low and restarts a full half period
    always @* begin
        next_div_cnt = div_cnt;
        next_refout_clk = refout_clk;
        if (!refout_run) begin
            next_div_cnt = 8'h00;
            next_refout_clk = 1'b0;
        end else if (div_wrap) begin
            next_div_cnt = 8'h00;
            next_refout_clk = ~refout_clk; // see R01, R02
        end else begin
            next_div_cnt = div_cnt + 8'h01;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            div_cnt <= 8'h00;
            refout_clk <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            refout_clk <= next_refout_clk;
        end
    end

    // ----------------------------------------------------------------
    // lock indicator pin
    // ----------------------------------------------------------------
    reg next_lock_pin;

    // the pin mirrors the live synchronised level, not the sticky flag,
    // so it drops as soon as the loop unlocks
    always @* begin
        next_lock_pin = 1'b0;
        if (lock_pin_enable_bit) begin
            next_lock_pin = lock_s2; // see R09
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            lock_pin <= 1'b0;
        end else begin
            lock_pin <= next_lock_pin;
        end
    end

    // ----------------------------------------------------------------
    // vco settings
    // ----------------------------------------------------------------
    // trim and band are passed straight to the analog side; their coding is
    // chosen by software from the channel plan
    assign vco_band_select = vco_cfg[`SCLK_VCO_BAND_LSB +: `SCLK_VCO_BAND_W]; // see R05
    assign vco_tank_trim = vco_cfg[`SCLK_VCO_TRIM_LSB +: `SCLK_VCO_TRIM_W]; // see R06

endmodule

// File: tb/sclk_synth_ctrl_assertions.sv
// Purpose: port checks for the synthesizer control block
// Assumes: bus inputs change just after a rising clk edge
// Notes: the sleep and lock latencies include two synchroniser flops
`timescale 1ns/100ps
`include "sclk_defs.vh"
module sclk_synth_ctrl_assertions #(
    parameter ADDR_W = 4,
    parameter DATA_W = 8
) (
    input wire clk,
    input wire rst_n,
    input wire [ADDR_W-1:0] reg_addr,
    input wire [DATA_W-1:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    input wire [DATA_W-1:0] reg_rdata,
    input wire sleep_mode,
    input wire lock_detect,
    input wire refout_clk,
    input wire lock_pin,
    input wire [2:0] vco_band_select,
    input wire [1:0] vco_tank_trim,
    input wire irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_RDATA_IDLE: assert property (
        !$past(reg_read) |-> reg_rdata == 8'h00) else $error("read data not idle");
    AST_STATUS_LIVE: assert property (
        lock_detect [*5] ##0 (reg_read && reg_addr == `SCLK_REG_STATUS) |=> reg_rdata[0])
        else $error("live lock not readable");
    AST_LOCKPIN_SRC: assert property (
        lock_pin |-> $past(lock_detect, 3)) else $error("lock pin without lock");
    AST_SLEEP_OFF: assert property (
        sleep_mode [*4] |-> !refout_clk) else $error("clock output in sleep");
    AST_RESET_RUN: assert property (
        $rose(rst_n) |-> ##[1:4] refout_clk) else $error("clock output idle after reset");
    AST_REFOUT_OFF: assert property (
        reg_write && reg_addr == `SCLK_REG_REFOUT && !reg_wdata[7] |-> ##2 !refout_clk)
        else $error("clock output still on");
    AST_VCO_WRITE: assert property (
        reg_write && reg_addr == `SCLK_REG_VCO |=> vco_tank_trim == $past(reg_wdata[5:4])
        && vco_band_select == $past(reg_wdata[2:0])) else $error("vco fields not loaded");
    AST_VCO_HOLD: assert property (
        !(reg_write && reg_addr == `SCLK_REG_VCO) |=> $stable(vco_band_select)
        && $stable(vco_tank_trim)) else $error("vco fields moved");
    cover property (reg_write && reg_addr == `SCLK_REG_VCO);
    cover property (lock_pin);
    cover property (irq);
endmodule
bind sclk_synth_ctrl sclk_synth_ctrl_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_inst (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .sleep_mode(sleep_mode), .lock_detect(lock_detect), .refout_clk(refout_clk),
    .lock_pin(lock_pin), .vco_band_select(vco_band_select),
    .vco_tank_trim(vco_tank_trim), .irq(irq));

// File: tb/sclk_mcu_model.sv
// Purpose: companion controller issuing register cycles
// Assumes: slave never stalls, read data stand one cycle after the strobe
// Notes: strobes drop at the same edge that takes them
`timescale 1ns/100ps
module sclk_mcu_model (
    input wire clk,
    output logic [3:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    input wire [7:0] reg_rdata
);
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end
    // band, trim and flag clears all go out as whole words
    // synthesizer dividers sit outside this block's map, never driven here
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        v = reg_rdata;
    endtask
endmodule

// File: tb/synth_clkout_lock_control_test.sv
// Purpose: self-checking bench for the synthesizer control block
// Assumes: clk stands in for the crystal reference
// Notes: output toggles are counted over 16 cycles
`timescale 1ns/100ps
`include "sclk_defs.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR %0t got %h want %h", $time, a, b); end end
module synth_clkout_lock_control_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sleep_mode = 1'b0;
    logic lock_detect = 1'b0;
    wire [3:0] reg_addr;
    wire [7:0] reg_wdata, reg_rdata;
    wire reg_write, reg_read, refout_clk, lock_pin, irq;
    wire [2:0] vco_band_select;
    wire [1:0] vco_tank_trim;
    logic [7:0] d;
    int bad_count = 0, tests_run = 0, cyc = 0;
    always #5 clk = ~clk;
    sclk_mcu_model sclk_mcu_model_inst (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
    sclk_synth_ctrl sclk_synth_ctrl_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .sleep_mode(sleep_mode), .lock_detect(lock_detect),
        .refout_clk(refout_clk), .lock_pin(lock_pin), .vco_band_select(vco_band_select),
        .vco_tank_trim(vco_tank_trim), .irq(irq));
    task automatic complete_run;
        if (bad_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic edges(input int want);
        logic p;
        int c;
        c = 0;
        repeat (5) @(negedge clk);
        p = refout_clk;
        repeat (16) begin
            @(negedge clk);
            if (refout_clk !== p) c++;
            p = refout_clk;
        end
        `CHK(c, want)
    endtask
    task automatic t_refout;
        sclk_mcu_model_inst.rd(`SCLK_REG_REFOUT, d);
        `CHK(d, 8'h80)
        edges(16);
        sclk_mcu_model_inst.wr(`SCLK_REG_REFOUT, 8'h82);
        edges(4);
        sclk_mcu_model_inst.wr(`SCLK_REG_REFOUT, 8'h02);
        edges(0);
        sclk_mcu_model_inst.wr(`SCLK_REG_REFOUT, 8'h80);
        sleep_mode <= 1'b1;
        edges(0);
        sleep_mode <= 1'b0;
        edges(16);
    endtask
    task automatic t_vco;
        for (int b = 0; b < 6; b++) begin
            sclk_mcu_model_inst.wr(`SCLK_REG_VCO, {2'b00, b[1:0], 1'b0, b[2:0]});
            sclk_mcu_model_inst.rd(`SCLK_REG_VCO, d);
            `CHK(d, {2'b00, b[1:0], 1'b0, b[2:0]})
            `CHK({vco_tank_trim, vco_band_select}, {b[1:0], b[2:0]})
        end
    endtask
    task automatic t_lock;
        sclk_mcu_model_inst.wr(`SCLK_REG_IRQ_CTRL, 8'h01);
        lock_detect <= 1'b1;
        sclk_mcu_model_inst.rd(4'hF, d);
        `CHK(d, 8'h00)
        sclk_mcu_model_inst.rd(`SCLK_REG_STATUS, d);
        `CHK(d, 8'h01)
        sclk_mcu_model_inst.rd(`SCLK_REG_IRQ_STAT, d);
        `CHK({d, lock_pin, irq}, 10'b0000000110)
        sclk_mcu_model_inst.wr(`SCLK_REG_IRQ_MASK, 8'h01);
        lock_detect <= 1'b0;
        repeat (4) @(posedge clk);
        sclk_mcu_model_inst.rd(`SCLK_REG_IRQ_STAT, d);
        `CHK({d, lock_pin, irq}, 10'b0000001101)
        sclk_mcu_model_inst.wr(`SCLK_REG_IRQ_STAT, 8'h02);
        sclk_mcu_model_inst.rd(`SCLK_REG_IRQ_STAT, d);
        `CHK({d, irq}, 9'b000000011)
        sclk_mcu_model_inst.wr(`SCLK_REG_IRQ_STAT, 8'h01);
        sclk_mcu_model_inst.wr(`SCLK_REG_IRQ_CTRL, 8'h00);
        lock_detect <= 1'b1;
        repeat (4) @(posedge clk);
        sclk_mcu_model_inst.rd(`SCLK_REG_IRQ_STAT, d);
        `CHK({d, lock_pin, irq}, 10'b0000000101)
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_refout();
        t_vco();
        t_lock();
        complete_run();
    end
endmodule
